// file: bench/cev_comp_model.sv
// cev_comp_model: behavioural analog comparator
// assumes: input voltages in millivolts from the bench
`timescale 1ns/1ps
module cev_comp_model (
  input  wire logic [11:0] pos_mv,
  input  wire logic [11:0] neg_mv,
  input  wire logic        power_off,
  output logic             comp_out
);
  assign comp_out = !power_off && (pos_mv > neg_mv);
endmodule // cev_comp_model

// file: bench/cev_properties.sv
// cev_properties: port checks for the comparator event block
// assumes: bound to cev_comparator_ctrl, one clock
`timescale 1ns/1ps
module cev_properties (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       global_irq_enable,
  input wire logic       irq_vector_ack,
  input wire logic       comp_power_off,
  input wire logic       comp_irq_req,
  input wire logic       irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_resv_zero: assert property (!reg_rdata[6] && !reg_rdata[2])
    else $error("reserved bit high");
  a_power_follow: assert property (reg_wr && reg_addr == 4'h0 ##1 !reg_wr
    |=> comp_power_off == $past(reg_wdata[7], 2)) else $error("power off wrong");
  a_req_global: assert property (comp_irq_req |-> $past(global_irq_enable))
    else $error("request without global");
  a_enable_off: assert property (reg_wr && reg_addr == 4'h0 && !reg_wdata[3]
    |-> ##2 !comp_irq_req) else $error("request while disabled");
  a_ack_block: assert property (irq_vector_ack |=> !comp_irq_req)
    else $error("request after ack");
  a_reset_clear: assert property ($fell(rst) |-> !comp_power_off && !irq)
    else $error("output set after reset");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data without read");
  a_unmapped_zero: assert property (reg_rd && reg_addr > 4'h2 |=> !reg_rdata)
    else $error("unmapped read nonzero");
endmodule // cev_properties

// file: bench/tb.sv
// tb: self-checking bench for cev_comparator_ctrl
// assumes: comparator model on the analog side
`timescale 1ns/1ps
module tb;
  logic        clk, rst, wr_s, rd_s, bop, gie, ack, pwr, req, irq, cmp;
  logic [3:0]  addr;
  logic [7:0]  wd, rdat;
  logic [11:0] pos;
  int          failures, checks;
  // select, start, end, flag
  logic [4:0]  rows [8] = '{5'h03, 5'h05, 5'h0a, 5'h0c, 5'h12, 5'h15, 5'h1b, 5'h1c};
  cev_comp_model model_u (.pos_mv(pos), .neg_mv(12'h100), .power_off(pwr), .comp_out(cmp));
  cev_comparator_ctrl dut_u (.clk(clk), .rst(rst), .reg_addr(addr), .reg_wdata(wd),
    .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdat), .bit_op(bop), .comp_out_async(cmp),
    .global_irq_enable(gie), .irq_vector_ack(ack), .comp_power_off(pwr),
    .comp_irq_req(req), .irq(irq));
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d, logic b);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr_s <= 1'b1;
    bop <= b;
    @(posedge clk);
    wr_s <= 1'b0;
    bop <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [7:0] e, string n);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk(n, rdat, e);
  endtask
  task automatic lvl(logic b);
    pos <= b ? 12'h200 : 12'h080;
    step(5);
  endtask
  task automatic summarize();
    if (failures == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    {wr_s, rd_s, bop, gie, ack, addr, wd} = '0;
    rst = 1'b1;
    pos = 12'h080;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(4'h0, 8'h00, "ctrl");
    foreach (rows[i]) begin
      lvl(rows[i][2]);
      wr(4'h0, {3'h0, 1'b1, 2'h0, rows[i][4:3]}, 1'b0);
      lvl(rows[i][1]);
      rd(4'h0, {2'h0, rows[i][1:0], 2'h0, rows[i][4:3]}, "event");
    end
    wr(4'h1, 8'h00, 1'b0);
    wr(4'h0, 8'h1b, 1'b0);
    gie <= 1'b1;
    lvl(1'b1);
    chk("masked", {7'h0, irq}, 8'h00);
    chk("req", {7'h0, req}, 8'h01);
    @(posedge clk);
    gie <= 1'b0;
    step(2);
    chk("no global", {7'h0, req}, 8'h00);
    wr(4'h1, 8'h01, 1'b0);
    gie <= 1'b1;
    step(2);
    chk("irq", {7'h0, irq}, 8'h01);
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    step(1);
    chk("acked", {7'h0, req}, 8'h00);
    rd(4'h0, 8'h2b, "ack flag");
    wr(4'h2, 8'h01, 1'b0);
    step(2);
    chk("status clr", {7'h0, irq}, 8'h00);
    lvl(1'b0);
    lvl(1'b1);
    wr(4'h0, 8'h0b, 1'b0);
    rd(4'h0, 8'h3b, "flag kept");
    wr(4'h0, 8'h0b, 1'b1);
    rd(4'h0, 8'h2b, "bit op");
    wr(4'h0, 8'h03, 1'b0);
    wr(4'h0, 8'h80, 1'b0);
    step(1);
    chk("power", {7'h0, pwr}, 8'h01);
    step(4);
    rd(4'h0, 8'h90, "off ctrl");
    chk("off req", {7'h0, req}, 8'h00);
    rd(4'hf, 8'h00, "unmapped");
    // mid-run reset with control bits and flag set
    @(posedge clk);
    rst <= 1'b1;
    pos <= 12'h080;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(4'h0, 8'h00, "reset ctrl");
    chk("reset irq", {7'h0, irq}, 8'h00);
    chk("reset pwr", {7'h0, pwr}, 8'h00);
    summarize();
  end
endmodule // tb
bind cev_comparator_ctrl cev_properties prop_u (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .global_irq_enable(global_irq_enable), .irq_vector_ack(irq_vector_ack),
  .comp_power_off(comp_power_off), .comp_irq_req(comp_irq_req), .irq(irq));

// file: pkg/cev_pkg.sv
// cev_pkg: constants for the comparator event control block
// assumes: one clock domain, 8-bit register port
package cev_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 4;
  // register indices
  localparam logic [3:0] CTRL_STATUS_ADDR = 4'h0;
  localparam logic [3:0] IRQ_MASK_ADDR = 4'h1;
  localparam logic [3:0] IRQ_STATUS_ADDR = 4'h2;
  // control/status field positions
  localparam int unsigned POWER_OFF_BIT = 7;
  localparam int unsigned RESV_HI_BIT = 6;
  localparam int unsigned RESULT_BIT = 5;
  localparam int unsigned EVENT_FLAG_BIT = 4;
  localparam int unsigned IRQ_ENABLE_BIT = 3;
  localparam int unsigned RESV_LO_BIT = 2;
  localparam int unsigned SEL_HIGH_BIT = 1;
  localparam int unsigned SEL_LOW_BIT = 0;
  // summary interrupt status bits
  localparam int unsigned IRQ_EVENT_BIT = 0;
  localparam int unsigned IRQ_BITS = 1;
  localparam logic [1:0] SEL_RESET = 2'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  typedef enum logic [1:0] {
    CEV_SEL_TOGGLE  = 2'h0,
    CEV_SEL_RESERVED = 2'h1,
    CEV_SEL_FALL    = 2'h2,
    CEV_SEL_RISE    = 2'h3
  } cev_sel_t;
endpackage

// file: rtl/cev_comparator_ctrl.sv
// cev_comparator_ctrl: control/status logic for an on-chip comparator
// assumes: analog comparator output arrives asynchronously; cpu supplies
// global interrupt enable and vector acknowledge on clk
//
// Overview of operation
// - result is one when positive above negative
// - bit 7 powers comparator off
// - bit 5 reads live comparator result
// - bit 4 flag set on selected event
// - vectoring to handler clears flag
// - writing one clears flag, zero keeps
// - bit set/clear on others clears flag
// - request needs enable bit and global enable
// - select: toggle, reserved, falling, rising
// - bits 6 and 2 read zero
`timescale 1ns/1ps
module cev_comparator_ctrl (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic [cev_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [cev_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [cev_pkg::DATA_W-1:0]  reg_rdata,
  input  wire logic                        bit_op,
  input  wire logic                        comp_out_async,
  input  wire logic                        global_irq_enable,
  input  wire logic                        irq_vector_ack,
  output logic                             comp_power_off,
  output logic                             comp_irq_req,
  output logic                             irq
);
  logic                                power_off_q;
  logic                                event_flag_q;
  logic                                irq_enable_q;
  logic [1:0]                          sel_q;
  logic [cev_pkg::IRQ_BITS-1:0]        irq_stat_q;
  logic [cev_pkg::IRQ_BITS-1:0]        irq_mask_q;
  logic                                result_s;
  logic                                result_prev;
  logic                                event_hit;
  logic                                ctrl_wr;
  logic [cev_pkg::DATA_W-1:0]          ctrl_view;
  logic [cev_pkg::DATA_W-1:0]          rdata_d;
  cev_pkg::cev_sel_t                   sel_e;

  cev_edge_sync u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (comp_out_async),
    .level_q  (result_s),
    .prev_q   (result_prev)
  );

  assign sel_e   = cev_pkg::cev_sel_t'(sel_q);
  assign ctrl_wr = reg_wr && (reg_addr == cev_pkg::CTRL_STATUS_ADDR);

  always_comb begin
    unique case (sel_e)
      cev_pkg::CEV_SEL_TOGGLE:   event_hit = result_s ^ result_prev;
      cev_pkg::CEV_SEL_RESERVED: event_hit = 1'b0;
      cev_pkg::CEV_SEL_FALL:     event_hit = result_prev & ~result_s;
      cev_pkg::CEV_SEL_RISE:     event_hit = result_s & ~result_prev;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      power_off_q  <= 1'b0;
      irq_enable_q <= 1'b0;
      sel_q        <= cev_pkg::SEL_RESET;
    end else if (ctrl_wr) begin
      power_off_q  <= reg_wdata[cev_pkg::POWER_OFF_BIT];
      irq_enable_q <= reg_wdata[cev_pkg::IRQ_ENABLE_BIT];
      sel_q        <= reg_wdata[cev_pkg::SEL_HIGH_BIT:cev_pkg::SEL_LOW_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      event_flag_q <= 1'b0;
    end else if (event_hit) begin
      event_flag_q <= 1'b1;
    end else if (irq_vector_ack) begin
      event_flag_q <= 1'b0;
    end else if (ctrl_wr && (reg_wdata[cev_pkg::EVENT_FLAG_BIT] || bit_op)) begin
      event_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      comp_irq_req   <= 1'b0;
      comp_power_off <= 1'b0;
    end else begin
      comp_irq_req   <= event_flag_q & irq_enable_q & global_irq_enable & ~irq_vector_ack;
      comp_power_off <= power_off_q;
    end
  end

  // sticky summary status, write one clears, set wins
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
    end else begin
      if (reg_wr && (reg_addr == cev_pkg::IRQ_MASK_ADDR)) begin
        irq_mask_q <= reg_wdata[cev_pkg::IRQ_BITS-1:0];
      end
      if (event_hit) begin
        irq_stat_q[cev_pkg::IRQ_EVENT_BIT] <= 1'b1;
      end else if (reg_wr && (reg_addr == cev_pkg::IRQ_STATUS_ADDR)
                   && reg_wdata[cev_pkg::IRQ_EVENT_BIT]) begin
        irq_stat_q[cev_pkg::IRQ_EVENT_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  always_comb begin
    ctrl_view = cev_pkg::BYTE_ZERO;
    ctrl_view[cev_pkg::POWER_OFF_BIT]  = power_off_q;
    ctrl_view[cev_pkg::RESULT_BIT]     = result_s;
    ctrl_view[cev_pkg::EVENT_FLAG_BIT] = event_flag_q;
    ctrl_view[cev_pkg::IRQ_ENABLE_BIT] = irq_enable_q;
    ctrl_view[cev_pkg::SEL_HIGH_BIT:cev_pkg::SEL_LOW_BIT] = sel_q;
  end

  always_comb begin
    rdata_d = cev_pkg::BYTE_ZERO;
    unique case (reg_addr)
      cev_pkg::CTRL_STATUS_ADDR: rdata_d = ctrl_view;
      cev_pkg::IRQ_MASK_ADDR:    rdata_d[cev_pkg::IRQ_BITS-1:0] = irq_mask_q;
      cev_pkg::IRQ_STATUS_ADDR:  rdata_d[cev_pkg::IRQ_BITS-1:0] = irq_stat_q;
      default:                   rdata_d = cev_pkg::BYTE_ZERO;
    endcase
  end

  // read data one cycle after strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= cev_pkg::BYTE_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= cev_pkg::BYTE_ZERO;
    end
  end
endmodule // cev_comparator_ctrl

// file: rtl/cev_edge_sync.sv
// cev_edge_sync: two-flop synchroniser plus previous-value stage
// assumes: async input level, single clock, synchronous reset
`timescale 1ns/1ps
module cev_edge_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic async_in,
  output logic      level_q,
  output logic      prev_q
);
  logic meta_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q  <= 1'b0;
      level_q <= 1'b0;
      prev_q  <= 1'b0;
    end else begin
      meta_q  <= async_in;
      level_q <= meta_q;
      prev_q  <= level_q;
    end
  end
endmodule // cev_edge_sync
